// >>> bswpm_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "bswpm_params.svh"
module bswpm_top import bswpm_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `BSWPM_TEMP_TICK_CYC // temp timer tick
) (
  input  wire logic        clk,                   // 100 MHz clock
  input  wire logic        rst_n,                 // async reset, active low
  input  wire logic [7:0]  addr,                  // register address
  input  wire logic [7:0]  wdata,                 // write data
  input  wire logic        wr,                    // write strobe
  input  wire logic        rd,                    // read strobe
  output var  logic [7:0]  rdata_q,               // read data, cycle after rd
  input  wire logic        bulk_voltage_monitor_in, // pin: bulk below 1.2 V
  input  wire logic        vdd_low_in,            // pin: main below 2.75 V
  input  wire logic        battery_ok_in,         // pin: battery valid
  input  wire logic        uart_rx_in,            // pin: uart receive
  input  wire logic        ext_interrupt_a_n,     // pin: interrupt a, low
  input  wire logic        ext_interrupt_b_n,     // pin: interrupt b, low
  input  wire logic        ext_reset_n,           // pin: external reset, low
  input  wire logic        rtc_midnight_in,       // rtc midnight pulse
  input  wire logic        rtc_alarm_in,          // rtc alarm pulse
  input  wire logic [7:0]  temp_result_in,        // temperature result
  input  wire logic        temp_done_in,          // result valid pulse
  output var  logic        temp_start_q,          // start a temp conversion
  output var  logic        switched_supply_out,   // switched rail enable, off when vdd low and battery bad
  output var  logic        line_supply_q,         // main supply path enable
  output var  logic        analog_domain_supply,  // analog regulator enable
  output var  logic        digital_domain_supply, // digital regulator enable
  output var  logic        core_hold_q,           // core held in reset
  output var  logic        rtc_run_q,             // rtc timebase enable
  output var  logic        lcd_enable_q,          // display driver on
  output var  logic        lcd_blink_q,           // display blink in sleep
  output var  logic [2:0]  mode_q                 // current power mode
);
  localparam logic [4:0]  CORE_RST = 5'(`BSWPM_CORE_RST_CYC);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // pin synchronisers
  logic [6:0]  meta_q;
  logic [6:0]  sync_q;
  logic        rx_prev_q;
  logic [6:0]  pins;
  logic        bulk_s;
  logic        vdd_low_s;
  logic        bat_ok_s;
  logic        rx_s;
  logic        inta_s;
  logic        intb_s;
  logic        rstpin_s;

  assign pins = {ext_reset_n, ext_interrupt_b_n, ext_interrupt_a_n,
                 uart_rx_in, battery_ok_in, vdd_low_in, bulk_voltage_monitor_in};

  // two flops per pin, plus one more on rx for edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q    <= `BSWPM_PIN_RST;
      sync_q    <= `BSWPM_PIN_RST;
      rx_prev_q <= 1'b1;
    end else begin
      meta_q    <= pins;
      sync_q    <= meta_q;
      rx_prev_q <= sync_q[3];
    end
  end

  assign bulk_s    = sync_q[0];
  assign vdd_low_s = sync_q[1];
  assign bat_ok_s  = sync_q[2];
  assign rx_s      = sync_q[3];
  assign inta_s    = sync_q[4];
  assign intb_s    = sync_q[5];
  assign rstpin_s  = sync_q[6];

  // supply switch with hysteresis and timeout
  logic on_battery;
  logic fail_s;

  assign fail_s = bulk_s | vdd_low_s;

  bswpm_switch u_switch (
    .clk          (clk),
    .rst_n        (rst_n),
    .fail_s       (fail_s),
    .on_battery_q (on_battery)
  );

  // software registers
  bswpm_byte_t wake_flags_q;
  bswpm_byte_t wake_flags_d;
  bswpm_byte_t wake_en_q;
  bswpm_byte_t sleep_ctl_q;
  bswpm_byte_t temp_ivl_q;
  bswpm_byte_t temp_step_q;
  bswpm_byte_t temp_last_q;

  // address decode
  logic wr_wflags;
  logic wr_wen;
  logic wr_sctl;
  logic wr_ivl;
  logic wr_step;
  logic sleep_req;

  assign wr_wflags = wr && (addr == `BSWPM_ADDR_WAKE_FLAGS);
  assign wr_wen    = wr && (addr == `BSWPM_ADDR_WAKE_EN);
  assign wr_sctl   = wr && (addr == `BSWPM_ADDR_SLEEP_CTL);
  assign wr_ivl    = wr && (addr == `BSWPM_ADDR_TEMP_IVL);
  assign wr_step   = wr && (addr == `BSWPM_ADDR_TEMP_STEP);
  assign sleep_req = wr_sctl && wdata[`BSWPM_SC_SLEEP];

  // mode state
  bswpm_mode_e mode_st_q;
  bswpm_mode_e mode_st_d;
  logic        in_sleep;
  logic        in_line;

  assign in_sleep = (mode_st_q == BSWPM_BAT_SLEEP);
  assign in_line  = (mode_st_q == BSWPM_LINE);

  // temperature change detection
  logic [7:0] temp_diff;
  logic       temp_wake;

  assign temp_diff = (temp_result_in > temp_last_q) ? temp_result_in - temp_last_q
                                                    : temp_last_q - temp_result_in;
  assign temp_wake = temp_done_in && (temp_diff > temp_step_q);

  // wake sources, only counted while asleep
  logic [7:0] wake_raw;
  logic [7:0] wake_en;
  logic [7:0] wake_vec;
  logic       wake_any;

  assign wake_raw[`BSWPM_WK_MIDNIGHT] = rtc_midnight_in;
  assign wake_raw[`BSWPM_WK_ALARM]    = rtc_alarm_in;
  assign wake_raw[`BSWPM_WK_SUPPLY]   = !on_battery;
  assign wake_raw[`BSWPM_WK_UART]     = rx_prev_q && !rx_s;
  assign wake_raw[`BSWPM_WK_TEMP]     = temp_wake;
  assign wake_raw[`BSWPM_WK_INT_A]    = !inta_s;
  assign wake_raw[`BSWPM_WK_INT_B]    = !intb_s;
  assign wake_raw[`BSWPM_WK_RESET]    = !rstpin_s;
  assign wake_en  = wake_en_q | `BSWPM_WAKE_FORCED;
  assign wake_vec = wake_raw & wake_en & {8{in_sleep}};
  assign wake_any = |wake_vec;

  // set wins over a software clear
  assign wake_flags_d = (wake_flags_q & ~(wr_wflags ? wdata : 8'h00))
                        | wake_vec;

  // mode transitions
  always_comb begin
    mode_st_d = mode_st_q;
    case (mode_st_q)
      BSWPM_LINE: begin
        if (on_battery) mode_st_d = BSWPM_BAT_RUN;
      end
      BSWPM_BAT_RUN: begin
        if (!on_battery) mode_st_d = BSWPM_LINE;
        else if (sleep_req) mode_st_d = BSWPM_BAT_SLEEP;
      end
      BSWPM_BAT_SLEEP: begin
        if (wake_any) begin
          mode_st_d = on_battery ? BSWPM_BAT_RUN : BSWPM_LINE;
        end
      end
      default: begin
        mode_st_d = BSWPM_LINE;
      end
    endcase
  end

  // core reset hold after power-up and after each wake
  logic [4:0] core_cnt_q;
  logic [4:0] core_cnt_d;
  logic       waking;

  assign waking     = in_sleep && (mode_st_d != BSWPM_BAT_SLEEP);
  assign core_cnt_d = waking ? CORE_RST :
                      (core_cnt_q != 5'h00) ? core_cnt_q - 5'h01 : 5'h00;

  // periodic temperature timer in sleep
  logic [31:0] tick_q;
  logic [7:0]  ivl_cnt_q;
  logic        tick_run;
  logic        tick_hit;
  logic        ivl_hit;

  assign tick_run = in_sleep && sleep_ctl_q[`BSWPM_SC_TEMP_EN];
  assign tick_hit = tick_run && (tick_q == TICK_LAST);
  assign ivl_hit  = tick_hit && (ivl_cnt_q >= temp_ivl_q - 8'h01);

  // state and counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_st_q    <= BSWPM_LINE;
      core_cnt_q   <= CORE_RST;
      tick_q       <= 32'h0000_0000;
      ivl_cnt_q    <= 8'h00;
      temp_start_q <= 1'b0;
    end else begin
      mode_st_q    <= mode_st_d;
      core_cnt_q   <= core_cnt_d;
      tick_q       <= (!tick_run || tick_hit) ? 32'h0000_0000 : tick_q + 32'h0000_0001;
      ivl_cnt_q    <= (!tick_run || ivl_hit) ? 8'h00 :
                      tick_hit ? ivl_cnt_q + 8'h01 : ivl_cnt_q;
      temp_start_q <= ivl_hit;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_flags_q <= 8'h00;
      wake_en_q    <= `BSWPM_WAKE_EN_RST;
      sleep_ctl_q  <= `BSWPM_SLEEP_CTL_RST;
      temp_ivl_q   <= `BSWPM_TEMP_IVL_RST;
      temp_step_q  <= `BSWPM_TEMP_STEP_RST;
      temp_last_q  <= 8'h00;
    end else begin
      wake_flags_q <= wake_flags_d;
      if (wr_wen) wake_en_q <= wdata;
      if (wr_sctl) sleep_ctl_q <= {wdata[7:1], 1'b0}; // sleep bit self-clears
      if (wr_ivl) temp_ivl_q <= wdata;
      if (wr_step) temp_step_q <= wdata;
      if (temp_done_in) temp_last_q <= temp_result_in;
    end
  end

  // read mux
  bswpm_byte_t flags_rd;
  bswpm_byte_t rd_mux;

  assign flags_rd = {5'h00, digital_domain_supply, analog_domain_supply,
                     on_battery};
  assign rd_mux = (addr == `BSWPM_ADDR_FLAGS)      ? flags_rd :
                  (addr == `BSWPM_ADDR_WAKE_FLAGS) ? wake_flags_q :
                  (addr == `BSWPM_ADDR_WAKE_EN)    ? wake_en_q :
                  (addr == `BSWPM_ADDR_SLEEP_CTL)  ? sleep_ctl_q :
                  (addr == `BSWPM_ADDR_TEMP_IVL)   ? temp_ivl_q :
                  (addr == `BSWPM_ADDR_TEMP_STEP)  ? temp_step_q : 8'h00;

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q               <= 8'h00;
      switched_supply_out   <= 1'b0;
      line_supply_q         <= 1'b0;
      analog_domain_supply  <= 1'b0;
      digital_domain_supply <= 1'b1;
      core_hold_q           <= 1'b1;
      rtc_run_q             <= 1'b1;
      lcd_enable_q          <= 1'b1;
      lcd_blink_q           <= 1'b0;
      mode_q                <= BSWPM_LINE;
    end else begin
      rdata_q               <= rd ? rd_mux : 8'h00;
      switched_supply_out   <= !vdd_low_s || bat_ok_s;
      line_supply_q         <= (mode_st_d == BSWPM_LINE);
      analog_domain_supply  <= (mode_st_d == BSWPM_LINE);
      digital_domain_supply <= (mode_st_d != BSWPM_BAT_SLEEP);
      core_hold_q           <= (core_cnt_d != 5'h00);
      rtc_run_q             <= 1'b1;
      lcd_enable_q          <= (mode_st_d != BSWPM_BAT_SLEEP)
                               || sleep_ctl_q[`BSWPM_SC_LCD_KEEP];
      lcd_blink_q           <= (mode_st_d == BSWPM_BAT_SLEEP)
                               && sleep_ctl_q[`BSWPM_SC_LCD_KEEP]
                               && sleep_ctl_q[`BSWPM_SC_LCD_BLINK];
      mode_q                <= mode_st_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_analog_off_bat: assert property (
    on_battery && !in_line |=> !analog_domain_supply)
    else $error("analog domain on while on battery");

  a_sleep_core_off: assert property (
    in_sleep |-> !digital_domain_supply)
    else $error("digital domain on during sleep");

  a_rtc_always_on: assert property (
    in_sleep |-> rtc_run_q)
    else $error("rtc stopped in sleep");

  a_wake_leaves: assert property (
    in_sleep && wake_any |=> !in_sleep ##0 digital_domain_supply)
    else $error("enabled wake did not leave sleep");

  a_wake_core_rst: assert property (
    $rose(digital_domain_supply) |-> core_hold_q [*8])
    else $error("core not held in reset after wake");

  a_status_read: assert property (
    rd && addr == `BSWPM_ADDR_FLAGS |=> rdata_q[`BSWPM_FLG_BATTERY] == $past(on_battery))
    else $error("status bit does not show switch position");

  a_sleep_cmd: assert property (
    mode_st_q == BSWPM_BAT_RUN && on_battery && sleep_req |=> in_sleep ##0 !digital_domain_supply)
    else $error("sleep command not honoured");

  a_line_only: assert property (
    !in_line |=> !line_supply_q || mode_q == BSWPM_LINE)
    else $error("main supply path on outside line mode");

  a_vsw_alive: assert property (
    bat_ok_s |=> switched_supply_out)
    else $error("switched supply dropped with battery valid");

  a_flag_held: assert property (
    !wr_wflags |=> (wake_flags_q & $past(wake_flags_q)) == $past(wake_flags_q))
    else $error("wake flag lost without a clear");

  a_flag_set_wins: assert property (
    wake_vec[`BSWPM_WK_UART] |=> wake_flags_q[`BSWPM_WK_UART])
    else $error("wake cause not latched");
endmodule // bswpm_top
`default_nettype wire

// >>> bswpm_params.svh
`ifndef BSWPM_PARAMS_SVH
`define BSWPM_PARAMS_SVH

// register offsets
`define BSWPM_ADDR_FLAGS      8'hF8
`define BSWPM_ADDR_WAKE_FLAGS 8'hF9
`define BSWPM_ADDR_WAKE_EN    8'hFA
`define BSWPM_ADDR_SLEEP_CTL  8'hFB
`define BSWPM_ADDR_TEMP_IVL   8'hFC
`define BSWPM_ADDR_TEMP_STEP  8'hFD

// power_mode_flags fields
`define BSWPM_FLG_BATTERY     0
`define BSWPM_FLG_ANALOG_ON   1
`define BSWPM_FLG_DIGITAL_ON  2

// wake source bit positions
`define BSWPM_WK_MIDNIGHT     0
`define BSWPM_WK_ALARM        1
`define BSWPM_WK_SUPPLY       2
`define BSWPM_WK_UART         3
`define BSWPM_WK_TEMP         4
`define BSWPM_WK_INT_A        5
`define BSWPM_WK_INT_B        6
`define BSWPM_WK_RESET        7

// sleep control fields
`define BSWPM_SC_SLEEP        0
`define BSWPM_SC_LCD_KEEP     1
`define BSWPM_SC_LCD_BLINK    2
`define BSWPM_SC_TEMP_EN      3

// reset values and forced wake enables
`define BSWPM_WAKE_EN_RST     8'h00
`define BSWPM_WAKE_FORCED     8'h8D
`define BSWPM_SLEEP_CTL_RST   8'h00
`define BSWPM_TEMP_IVL_RST    8'h3C
`define BSWPM_TEMP_STEP_RST   8'h02
`define BSWPM_PIN_RST         7'h78

// timing
`define BSWPM_CLK_PERIOD_NS   10
`define BSWPM_SW_TIMEOUT_NS   20000
`define BSWPM_SW_TIMEOUT_CYC  ((`BSWPM_SW_TIMEOUT_NS + `BSWPM_CLK_PERIOD_NS - 1) / `BSWPM_CLK_PERIOD_NS)
`define BSWPM_CORE_RST_NS     160
`define BSWPM_CORE_RST_CYC    ((`BSWPM_CORE_RST_NS + `BSWPM_CLK_PERIOD_NS - 1) / `BSWPM_CLK_PERIOD_NS)
`define BSWPM_TEMP_TICK_NS    1000000000
`define BSWPM_TEMP_TICK_CYC   (`BSWPM_TEMP_TICK_NS / `BSWPM_CLK_PERIOD_NS)

`endif

// >>> bswpm_pkg.sv
package bswpm_pkg;
  typedef enum logic [2:0] {
    BSWPM_LINE      = 3'b001,
    BSWPM_BAT_RUN   = 3'b010,
    BSWPM_BAT_SLEEP = 3'b100
  } bswpm_mode_e;
  typedef logic [7:0] bswpm_byte_t;
endpackage

// >>> bswpm_switch.sv
`timescale 1ns/10ps
`default_nettype none
`include "bswpm_params.svh"
module bswpm_switch import bswpm_pkg::*; (
  input  wire logic clk,          // system clock
  input  wire logic rst_n,        // async reset, active low
  input  wire logic fail_s,       // synced supply-fail condition
  output var  logic on_battery_q  // switch position, 1 = battery
);
  localparam logic [15:0] TMO = 16'(`BSWPM_SW_TIMEOUT_CYC);

  logic [15:0] ok_cnt_q;
  logic [15:0] ok_cnt_d;
  logic        on_battery_d;

  // any fail goes to battery at once; return needs a clean timeout
  assign ok_cnt_d     = fail_s ? 16'h0000 :
                        (ok_cnt_q == TMO) ? ok_cnt_q : ok_cnt_q + 16'h0001;
  assign on_battery_d = fail_s ? 1'b1 :
                        (ok_cnt_q == TMO) ? 1'b0 : on_battery_q;

  // counter and switch state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_cnt_q     <= 16'h0000;
      on_battery_q <= 1'b1;
    end else begin
      ok_cnt_q     <= ok_cnt_d;
      on_battery_q <= on_battery_d;
    end
  end

  a_fail_to_bat: assert property (@(posedge clk) disable iff (!rst_n)
    fail_s |=> on_battery_q)
    else $error("fail condition did not select battery");

  a_return_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(on_battery_q) |-> $past(!fail_s, 8) && $past(ok_cnt_q) == TMO)
    else $error("returned to line supply before timeout");
endmodule // bswpm_switch
`default_nettype wire

// >>> bswpm_top_fix_note_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> bswpm_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "bswpm_params.svh"
module bswpm_top_tb import bswpm_pkg::*; ;
  localparam int TICK = 4;
  logic       clk, rst_n, wr, rd, bulk, vdd_low, bat_ok, uart_rx;
  logic       int_a_n, int_b_n, ext_rst_n, midnight, alarm, temp_done;
  logic [7:0] addr, wdata, rdata_q, temp_res, rv, st;
  logic       temp_start_q, sw_sup, line_q, ana, dig, core_hold_q, rtc_run_q, lcd_en, lcd_bl;
  logic [2:0] mode_q;
  logic [31:0] lfsr;
  int         n_mismatch, checks_done, cyc, n, k;

  bswpm_top #(.TICK_CYCLES(TICK)) u_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .bulk_voltage_monitor_in(bulk), .vdd_low_in(vdd_low),
    .battery_ok_in(bat_ok), .uart_rx_in(uart_rx), .ext_interrupt_a_n(int_a_n),
    .ext_interrupt_b_n(int_b_n), .ext_reset_n(ext_rst_n), .rtc_midnight_in(midnight),
    .rtc_alarm_in(alarm), .temp_result_in(temp_res), .temp_done_in(temp_done),
    .temp_start_q(temp_start_q), .switched_supply_out(sw_sup), .line_supply_q(line_q),
    .analog_domain_supply(ana), .digital_domain_supply(dig), .core_hold_q(core_hold_q),
    .rtc_run_q(rtc_run_q), .lcd_enable_q(lcd_en), .lcd_blink_q(lcd_bl), .mode_q(mode_q));

  // free-running clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // galois-free shift register, taps fixed
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic rnd(output logic [7:0] r);
    lfsr = lfsr_next(lfsr);
    r = lfsr[7:0];
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data is looked at in the one cycle it stands
  task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata_q, exp);
  endtask

  task automatic wait_mode(input logic [2:0] exp, input int max, output int cnt);
    cnt = 0;
    while (mode_q !== exp && cnt < max) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("mode", 8'(mode_q), 8'(exp));
  endtask

  task automatic go_sleep(input logic [7:0] ctl);
    int c;
    wr_reg(`BSWPM_ADDR_WAKE_FLAGS, 8'hFF);
    wr_reg(`BSWPM_ADDR_SLEEP_CTL, ctl);
    wait_mode(BSWPM_BAT_SLEEP, 5, c);
  endtask

  task automatic tpulse(input logic [7:0] t);
    @(posedge clk);
    temp_res  <= t;
    temp_done <= 1'b1;
    @(posedge clk);
    temp_done <= 1'b0;
  endtask

  // drive one wake source by its bit position; 2 and 4 fall through to the reset pin
  task automatic fire(input int i);
    @(posedge clk);
    case (i)
      0: midnight <= 1'b1;
      1: alarm <= 1'b1;
      3: uart_rx <= 1'b0;
      5: int_a_n <= 1'b0;
      6: int_b_n <= 1'b0;
      default: ext_rst_n <= 1'b0;
    endcase
    @(posedge clk);
    midnight <= 1'b0;
    alarm    <= 1'b0;
  endtask

  task automatic idle_pins();
    @(posedge clk);
    uart_rx   <= 1'b1;
    int_a_n   <= 1'b1;
    int_b_n   <= 1'b1;
    ext_rst_n <= 1'b1;
  endtask

  // main sequence
  initial begin
    clk = 0; rst_n = 0; addr = 0; wdata = 0; wr = 0; rd = 0;
    bulk = 0; vdd_low = 0; bat_ok = 1; uart_rx = 1; int_a_n = 1; int_b_n = 1;
    ext_rst_n = 1; midnight = 0; alarm = 0; temp_res = 0; temp_done = 0;
    lfsr = 32'h527406C2; n_mismatch = 0; checks_done = 0; cyc = 0;
    repeat (5) @(posedge clk);
    #1;
    check("rtc_run", 8'(rtc_run_q), 8'h01);
    check("core_hold", 8'(core_hold_q), 8'h01);
    @(posedge clk);
    rst_n <= 1'b1;
    // switch starts on battery, then proves the supply before choosing line
    wait_mode(BSWPM_BAT_RUN, 5, n);
    wait_mode(BSWPM_LINE, 2200, n);
    check("line_supply", 8'(line_q), 8'h01);
    check("analog", 8'(ana), 8'h01);
    check("switched", 8'(sw_sup), 8'h01);
    chk_reg("flags", `BSWPM_ADDR_FLAGS, 8'h06);
    chk_reg("wake_en", `BSWPM_ADDR_WAKE_EN, `BSWPM_WAKE_EN_RST);
    chk_reg("sleep_ctl", `BSWPM_ADDR_SLEEP_CTL, `BSWPM_SLEEP_CTL_RST);
    chk_reg("temp_ivl", `BSWPM_ADDR_TEMP_IVL, `BSWPM_TEMP_IVL_RST);
    chk_reg("temp_step", `BSWPM_ADDR_TEMP_STEP, `BSWPM_TEMP_STEP_RST);
    for (k = 0; k < 4; k++) begin
      rnd(rv);
      chk_reg("unmapped", rv & 8'h7F, 8'h00);
      rnd(rv);
      wr_reg(`BSWPM_ADDR_TEMP_IVL, rv);
      chk_reg("temp_ivl_rw", `BSWPM_ADDR_TEMP_IVL, rv);
    end
    $display("test reset_and_registers done");
    // bulk monitor failure, then filtered bounce, then proven return
    @(posedge clk);
    bulk <= 1'b1;
    wait_mode(BSWPM_BAT_RUN, 10, n);
    check("analog_off", 8'(ana), 8'h00);
    check("line_off", 8'(line_q), 8'h00);
    check("digital_on", 8'(dig), 8'h01);
    chk_reg("flags_bat", `BSWPM_ADDR_FLAGS, 8'h05);
    @(posedge clk);
    bulk <= 1'b0;
    rnd(rv);
    repeat (500 + int'(rv)) @(posedge clk);
    #1;
    check("bounce_mode", 8'(mode_q), 8'(BSWPM_BAT_RUN));
    bulk <= 1'b1;
    repeat (10) @(posedge clk);
    bulk <= 1'b0;
    wait_mode(BSWPM_LINE, 2200, n);
    check("return_delay", 8'(n > 1999), 8'h01);
    @(posedge clk);
    vdd_low <= 1'b1;
    wait_mode(BSWPM_BAT_RUN, 10, n);
    $display("test supply_switch done");
    // sleep with display kept and blinking
    go_sleep(8'h07);
    check("digital_off", 8'(dig), 8'h00);
    check("rtc_sleep", 8'(rtc_run_q), 8'h01);
    check("lcd_keep", 8'(lcd_en), 8'h01);
    check("lcd_blink", 8'(lcd_bl), 8'h01);
    check("switched_sleep", 8'(sw_sup), 8'h01);
    wr_reg(`BSWPM_ADDR_WAKE_EN, 8'h00);
    fire(1);
    repeat (10) @(posedge clk);
    #1;
    check("alarm_masked", 8'(mode_q), 8'(BSWPM_BAT_SLEEP));
    chk_reg("no_flag", `BSWPM_ADDR_WAKE_FLAGS, 8'h00);
    // midnight wake is forced on even with every enable cleared
    fire(0);
    wait_mode(BSWPM_BAT_RUN, 10, n);
    go_sleep(8'h01);
    wr_reg(`BSWPM_ADDR_WAKE_EN, 8'hFF);
    // periodic temperature starts in sleep
    wr_reg(`BSWPM_ADDR_TEMP_IVL, 8'h03);
    wr_reg(`BSWPM_ADDR_SLEEP_CTL, 8'h08);
    n = 0;
    repeat (120) begin
      @(posedge clk);
      #1;
      if (temp_start_q === 1'b1) n++;
    end
    check("temp_starts", 8'(n >= 9 && n <= 11), 8'h01);
    check("lcd_off", 8'(lcd_en), 8'h00);
    $display("test sleep_features done");
    // each pin and timer wake, then sleep again
    for (k = 0; k < 8; k++) begin
      if (k == 2 || k == 4) continue;
      fire(k);
      wait_mode(BSWPM_BAT_RUN, 30, n);
      check("wake_core_hold", 8'(core_hold_q), 8'h01);
      check("wake_digital", 8'(dig), 8'h01);
      idle_pins();
      chk_reg("wake_flag", `BSWPM_ADDR_WAKE_FLAGS, 8'h01 << k);
      repeat (20) @(posedge clk);
      #1;
      check("core_release", 8'(core_hold_q), 8'h00);
      go_sleep(8'h01);
    end
    $display("test wake_sources done");
    // temperature step wake at and past the boundary
    rnd(st);
    st = st & 8'h0F;
    wr_reg(`BSWPM_ADDR_TEMP_STEP, st);
    rnd(rv);
    rv = rv & 8'h7F;
    tpulse(rv);
    repeat (10) @(posedge clk);
    go_sleep(8'h01);
    tpulse(rv + st);
    repeat (10) @(posedge clk);
    #1;
    check("temp_small", 8'(mode_q), 8'(BSWPM_BAT_SLEEP));
    tpulse(rv + st + st + 8'h01);
    wait_mode(BSWPM_BAT_RUN, 20, n);
    chk_reg("temp_flag", `BSWPM_ADDR_WAKE_FLAGS, 8'h10);
    go_sleep(8'h01);
    // main supply returns while asleep
    @(posedge clk);
    vdd_low <= 1'b0;
    wait_mode(BSWPM_LINE, 2200, n);
    chk_reg("supply_flag", `BSWPM_ADDR_WAKE_FLAGS, 8'h04);
    check("analog_back", 8'(ana), 8'h01);
    @(posedge clk);
    bat_ok  <= 1'b0;
    vdd_low <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("switched_dead", 8'(sw_sup), 8'h00);
    $display("test supply_restore done");
    print_verdict();
  end
endmodule // bswpm_top_tb
`default_nettype wire
